// >>> rtl/atb_pkg.sv
// Constants for the converter trim register bank
// Operation
// - Core A offset for input B, quarter phase, applies only under foreground calibration.
// - Core B offset for input A applies under foreground calibration, both modes.
// - Core B offset for input B applies under foreground calibration, both modes.
// - Dual-channel fine gains come from four registers starting 0x350.
// - Single-channel fine gains come from a separate set starting 0x354.
// - Fine gain field is bits 4:0; bits 7:5 reserved, reset zero.
// - Offset registers are 16 bits; value bits 11:0, bits 15:12 reserved, reset zero.
// - After initialisation trim registers load their defaults from fuse ROM.
package atb_pkg;

  // ==========================================================
  // Bus widths
  localparam int ADDR_W   = 12;
  localparam int DATA_W   = 16;
  localparam int NUM_REGS = 12;
  localparam int IDX_W    = 4;

  // ==========================================================
  // Register indices
  localparam int IDX_OFF_A_QB   = 0;
  localparam int IDX_OFF_B_IN_A = 1;
  localparam int IDX_OFF_B_IN_B = 2;
  localparam int IDX_GA0_DUAL   = 3;
  localparam int IDX_GA1_DUAL   = 4;
  localparam int IDX_GB0_DUAL   = 5;
  localparam int IDX_GB1_DUAL   = 6;
  localparam int IDX_GA0_SGL    = 7;
  localparam int IDX_GA1_SGL    = 8;
  localparam int IDX_GB0_SGL    = 9;
  localparam int IDX_GB1_SGL    = 10;
  localparam int IDX_CTRL       = 11;

  // ==========================================================
  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL          = 12'h348;
  localparam logic [ADDR_W-1:0] ADDR_OFF_A_QB      = 12'h34a;
  localparam logic [ADDR_W-1:0] ADDR_OFF_B_IN_A    = 12'h34c;
  localparam logic [ADDR_W-1:0] ADDR_OFF_B_IN_B    = 12'h34e;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_DUAL0    = 12'h350;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_SGL0     = 12'h354;

  localparam logic [ADDR_W-1:0] REG_ADDR [NUM_REGS] = '{
    12'h34a, 12'h34c, 12'h34e,
    12'h350, 12'h351, 12'h352, 12'h353,
    12'h354, 12'h355, 12'h356, 12'h357,
    12'h348
  };

  // ==========================================================
  // Register widths and fields
  localparam int OFF_REG_W   = 16;
  localparam int GAIN_REG_W  = 8;
  localparam int OFF_FIELD_W = 12;
  localparam int GAIN_FIELD_W = 5;
  localparam int NUM_TRIM    = 11;

  localparam logic [DATA_W-1:0] OFF_FIELD_MASK  = 16'h0fff;
  localparam logic [DATA_W-1:0] GAIN_FIELD_MASK = 16'h001f;
  localparam logic [DATA_W-1:0] TRIM_RESET      = 16'h0000;

  // ==========================================================
  // Control register fields
  localparam int CTRL_RELOAD_BIT = 0;
  localparam int CTRL_BUSY_BIT   = 1;
  localparam int CTRL_FGCAL_BIT  = 2;
  localparam int CTRL_SINGLE_BIT = 3;

  // ==========================================================
  // Fuse loader states
  typedef enum logic [1:0] {
    ATB_LD_IDLE,
    ATB_LD_REQ,
    ATB_LD_WAIT,
    ATB_LD_TAKE
  } atb_ld_state_t;

endpackage

// >>> rtl/atb_trim_reg.sv
// One trim register with fuse load and software write
`timescale 1ns/10ps
`default_nettype none
module atb_trim_reg #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             ce,
  input  wire logic             ld,
  input  wire logic [WIDTH-1:0] ld_data,
  input  wire logic             we,
  input  wire logic [WIDTH-1:0] wdata,
  output var  logic [WIDTH-1:0] q
);

  // ==========================================================
  // Storage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else if (ce) begin
      if (ld) begin
        q <= ld_data;
      end else if (we) begin
        q <= wdata;
      end
    end
  end

endmodule
`default_nettype wire

// >>> rtl/atb_trim_bank.sv
// Converter trim register bank top
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module atb_trim_bank #(
  parameter int ADDR_W   = atb_pkg::ADDR_W,
  parameter int DATA_W   = atb_pkg::DATA_W,
  parameter int NUM_TRIM = atb_pkg::NUM_TRIM
) (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     ce,
  input  wire logic [ADDR_W-1:0]        addr,
  input  wire logic [DATA_W-1:0]        wr_data,
  input  wire logic                     wr_en,
  input  wire logic                     rd_en,
  output logic      [DATA_W-1:0]        rd_data_q,
  input  wire logic                     sample_a_in_b_quarter,
  output logic                          fuse_rd_q,
  output logic      [atb_pkg::IDX_W-1:0] fuse_addr_q,
  input  wire logic [DATA_W-1:0]        fuse_data,
  output logic                          load_busy_q,
  output logic      [atb_pkg::OFF_FIELD_W-1:0] off_a_in_b_qtr_q,
  output logic      [atb_pkg::OFF_FIELD_W-1:0] off_b_in_a_q,
  output logic      [atb_pkg::OFF_FIELD_W-1:0] off_b_in_b_q,
  output logic      [atb_pkg::GAIN_FIELD_W-1:0] gain_a0_q,
  output logic      [atb_pkg::GAIN_FIELD_W-1:0] gain_a1_q,
  output logic      [atb_pkg::GAIN_FIELD_W-1:0] gain_b0_q,
  output logic      [atb_pkg::GAIN_FIELD_W-1:0] gain_b1_q
);

  // ==========================================================
  // Declarations
  localparam logic [atb_pkg::IDX_W-1:0] LAST_IDX =
    atb_pkg::IDX_W'(atb_pkg::NUM_TRIM - 1);
  localparam logic [atb_pkg::IDX_W-1:0] IDX_ONE = 4'h1;
  localparam logic [atb_pkg::IDX_W-1:0] IDX_ZERO = 4'h0;

  logic [DATA_W-1:0]          trim_q [NUM_TRIM];
  logic [NUM_TRIM-1:0]        hit;
  logic [NUM_TRIM-1:0]        trim_we;
  logic [NUM_TRIM-1:0]        trim_ld;
  logic                       ctrl_hit;
  logic                       ctrl_we;
  logic                       fgcal_q;
  logic                       single_q;
  logic                       reload_req;
  logic                       start_q;
  atb_pkg::atb_ld_state_t     ld_state_q;
  logic [atb_pkg::IDX_W-1:0]  ld_idx_q;
  logic                       ld_take;
  logic [DATA_W-1:0]          rd_mux;
  logic [DATA_W-1:0]          ctrl_view;
  logic [atb_pkg::GAIN_FIELD_W-1:0] gain_a0_d;
  logic [atb_pkg::GAIN_FIELD_W-1:0] gain_a1_d;
  logic [atb_pkg::GAIN_FIELD_W-1:0] gain_b0_d;
  logic [atb_pkg::GAIN_FIELD_W-1:0] gain_b1_d;

  // ==========================================================
  // Address decode
  always_comb begin
    for (int i = 0; i < NUM_TRIM; i++) begin
      hit[i] = (addr == atb_pkg::REG_ADDR[i]);
    end
  end

  assign ctrl_hit = (addr == atb_pkg::ADDR_CTRL);
  assign ctrl_we  = wr_en && ctrl_hit;

  // Writes to trim registers are dropped while the fuse load runs
  always_comb begin
    for (int i = 0; i < NUM_TRIM; i++) begin
      trim_we[i] = wr_en && hit[i] && !load_busy_q;
    end
  end

  assign reload_req = ctrl_we && wr_data[atb_pkg::CTRL_RELOAD_BIT];

  // ==========================================================
  // Trim register storage
  genvar g;
  generate
    for (g = 0; g < NUM_TRIM; g++) begin : g_trim
      localparam int W = (g <= atb_pkg::IDX_OFF_B_IN_B) ?
        atb_pkg::OFF_REG_W : atb_pkg::GAIN_REG_W;
      logic [W-1:0] q_w;

      atb_trim_reg #(
        .WIDTH (W)
      ) u_reg (
        .clk     (clk),
        .resetn  (resetn),
        .ce      (ce),
        .ld      (trim_ld[g]),
        .ld_data (fuse_data[W-1:0]),
        .we      (trim_we[g]),
        .wdata   (wr_data[W-1:0]),
        .q       (q_w)
      );

      // Reserved upper bits stored as written, unused bus bits read zero
      assign trim_q[g] = DATA_W'(q_w);
      assign trim_ld[g] = ld_take && (ld_idx_q == atb_pkg::IDX_W'(g));
    end
  endgenerate

  // ==========================================================
  // Control register
  // Calibration off after reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fgcal_q <= 1'b0;
    end else if (ce) begin
      if (ctrl_we) begin
        fgcal_q <= wr_data[atb_pkg::CTRL_FGCAL_BIT];
      end
    end
  end

  // Dual-channel mode after reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      single_q <= 1'b0;
    end else if (ce) begin
      if (ctrl_we) begin
        single_q <= wr_data[atb_pkg::CTRL_SINGLE_BIT];
      end
    end
  end

  always_comb begin
    ctrl_view = '0;
    ctrl_view[atb_pkg::CTRL_BUSY_BIT]   = load_busy_q;
    ctrl_view[atb_pkg::CTRL_FGCAL_BIT]  = fgcal_q;
    ctrl_view[atb_pkg::CTRL_SINGLE_BIT] = single_q;
  end

  // ==========================================================
  // Fuse load request
  // Pending from reset, so defaults load straight after release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      start_q <= 1'b1;
    end else if (ce) begin
      if (reload_req) begin
        start_q <= 1'b1;
      end else if (ld_state_q == atb_pkg::ATB_LD_IDLE) begin
        start_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Fuse load sequencer
  // Three cycles a word: request, wait, take
  assign ld_take = (ld_state_q == atb_pkg::ATB_LD_TAKE);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ld_state_q <= atb_pkg::ATB_LD_IDLE;
    end else if (ce) begin
      unique case (ld_state_q)
        atb_pkg::ATB_LD_IDLE: begin
          if (start_q) begin
            ld_state_q <= atb_pkg::ATB_LD_REQ;
          end
        end
        atb_pkg::ATB_LD_REQ: begin
          ld_state_q <= atb_pkg::ATB_LD_WAIT;
        end
        atb_pkg::ATB_LD_WAIT: begin
          ld_state_q <= atb_pkg::ATB_LD_TAKE;
        end
        atb_pkg::ATB_LD_TAKE: begin
          if (ld_idx_q == LAST_IDX) begin
            ld_state_q <= atb_pkg::ATB_LD_IDLE;
          end else begin
            ld_state_q <= atb_pkg::ATB_LD_REQ;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ld_idx_q <= IDX_ZERO;
    end else if (ce) begin
      if (ld_state_q == atb_pkg::ATB_LD_IDLE) begin
        ld_idx_q <= IDX_ZERO;
      end else if (ld_take) begin
        ld_idx_q <= ld_idx_q + IDX_ONE;
      end
    end
  end

  // Fuse ROM port: read strobe one cycle, data one cycle later
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fuse_rd_q <= 1'b0;
    end else if (ce) begin
      fuse_rd_q <= (ld_state_q == atb_pkg::ATB_LD_REQ);
    end
  end

  // Word index held until the next request
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fuse_addr_q <= IDX_ZERO;
    end else if (ce) begin
      if (ld_state_q == atb_pkg::ATB_LD_REQ) begin
        fuse_addr_q <= ld_idx_q;
      end
    end
  end

  // Busy from reset until the last default is taken
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      load_busy_q <= 1'b1;
    end else if (ce) begin
      if (reload_req) begin
        load_busy_q <= 1'b1;
      end else if (ld_take && ld_idx_q == LAST_IDX && !start_q) begin
        load_busy_q <= 1'b0;
      end else if (ld_state_q == atb_pkg::ATB_LD_IDLE && !start_q) begin
        load_busy_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Read path
  always_comb begin
    rd_mux = '0;
    for (int i = 0; i < NUM_TRIM; i++) begin
      if (hit[i]) begin
        rd_mux = trim_q[i];
      end
    end
    if (ctrl_hit) begin
      rd_mux = ctrl_view;
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_q <= '0;
    end else if (ce) begin
      if (rd_en) begin
        rd_data_q <= rd_mux;
      end else begin
        rd_data_q <= '0;
      end
    end
  end

  // ==========================================================
  // Offsets applied to the cores
  // Quarter-phase offset only while core A samples input B
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      off_a_in_b_qtr_q <= '0;
    end else if (ce) begin
      if (fgcal_q && sample_a_in_b_quarter) begin
        off_a_in_b_qtr_q <=
          trim_q[atb_pkg::IDX_OFF_A_QB][atb_pkg::OFF_FIELD_W-1:0];
      end else begin
        off_a_in_b_qtr_q <= '0;
      end
    end
  end

  // Core B offsets in both channel modes, zero while calibration is off
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      off_b_in_a_q <= '0;
    end else if (ce) begin
      if (fgcal_q) begin
        off_b_in_a_q <=
          trim_q[atb_pkg::IDX_OFF_B_IN_A][atb_pkg::OFF_FIELD_W-1:0];
      end else begin
        off_b_in_a_q <= '0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      off_b_in_b_q <= '0;
    end else if (ce) begin
      if (fgcal_q) begin
        off_b_in_b_q <=
          trim_q[atb_pkg::IDX_OFF_B_IN_B][atb_pkg::OFF_FIELD_W-1:0];
      end else begin
        off_b_in_b_q <= '0;
      end
    end
  end

  // ==========================================================
  // Fine gains for the active channel mode
  // Both sets stay stored; the mode bit only steers which one drives
  always_comb begin
    gain_a0_d = trim_q[atb_pkg::IDX_GA0_DUAL][atb_pkg::GAIN_FIELD_W-1:0];
    gain_a1_d = trim_q[atb_pkg::IDX_GA1_DUAL][atb_pkg::GAIN_FIELD_W-1:0];
    gain_b0_d = trim_q[atb_pkg::IDX_GB0_DUAL][atb_pkg::GAIN_FIELD_W-1:0];
    gain_b1_d = trim_q[atb_pkg::IDX_GB1_DUAL][atb_pkg::GAIN_FIELD_W-1:0];
    if (single_q) begin
      gain_a0_d = trim_q[atb_pkg::IDX_GA0_SGL][atb_pkg::GAIN_FIELD_W-1:0];
      gain_a1_d = trim_q[atb_pkg::IDX_GA1_SGL][atb_pkg::GAIN_FIELD_W-1:0];
      gain_b0_d = trim_q[atb_pkg::IDX_GB0_SGL][atb_pkg::GAIN_FIELD_W-1:0];
      gain_b1_d = trim_q[atb_pkg::IDX_GB1_SGL][atb_pkg::GAIN_FIELD_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gain_a0_q <= '0;
    end else if (ce) begin
      gain_a0_q <= gain_a0_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gain_a1_q <= '0;
    end else if (ce) begin
      gain_a1_q <= gain_a1_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gain_b0_q <= '0;
    end else if (ce) begin
      gain_b0_q <= gain_b0_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gain_b1_q <= '0;
    end else if (ce) begin
      gain_b1_q <= gain_b1_d;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/atb_dummy_unused.sv
`default_nettype none
`default_nettype wire

// >>> bench/atb_trim_bank_assertions.sv
// Port checker of the trim register bank
`timescale 1ns/10ps
`default_nettype none
module atb_trim_bank_chk #(
  parameter int ADDR_W   = 12,
  parameter int DATA_W   = 16,
  parameter int NUM_TRIM = 11
) (
  input wire logic                             clk,
  input wire logic                             resetn,
  input wire logic                             ce,
  input wire logic [ADDR_W-1:0]                addr,
  input wire logic [DATA_W-1:0]                wr_data,
  input wire logic                             wr_en,
  input wire logic                             rd_en,
  input wire logic [DATA_W-1:0]                rd_data_q,
  input wire logic                             sample_a_in_b_quarter,
  input wire logic                             fuse_rd_q,
  input wire logic [atb_pkg::IDX_W-1:0]        fuse_addr_q,
  input wire logic [DATA_W-1:0]                fuse_data,
  input wire logic                             load_busy_q,
  input wire logic [atb_pkg::OFF_FIELD_W-1:0]  off_a_in_b_qtr_q,
  input wire logic [atb_pkg::OFF_FIELD_W-1:0]  off_b_in_a_q,
  input wire logic [atb_pkg::OFF_FIELD_W-1:0]  off_b_in_b_q,
  input wire logic [atb_pkg::GAIN_FIELD_W-1:0] gain_a0_q,
  input wire logic [atb_pkg::GAIN_FIELD_W-1:0] gain_a1_q,
  input wire logic [atb_pkg::GAIN_FIELD_W-1:0] gain_b0_q,
  input wire logic [atb_pkg::GAIN_FIELD_W-1:0] gain_b1_q
);
  // ==========================================================
  // Mirror of the calibration enable
  logic fg_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) fg_q <= 1'b0;
    else if (ce && wr_en && addr == atb_pkg::ADDR_CTRL) fg_q <= wr_data[atb_pkg::CTRL_FGCAL_BIT];
  end

  // ==========================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_wr_in_a;
    ce && wr_en && !load_busy_q && addr == atb_pkg::ADDR_OFF_B_IN_A;
  endsequence
  sequence s_rd_in_a;
    ce && rd_en && addr == atb_pkg::ADDR_OFF_B_IN_A;
  endsequence
  property p_readback;
    s_wr_in_a ##1 s_rd_in_a |=> rd_data_q == $past(wr_data, 2);
  endproperty
  property p_rd_idle;
    $past(ce) && !$past(rd_en) |-> rd_data_q == '0;
  endproperty
  property p_gain_hi;
    ce && rd_en && addr >= 12'h350 && addr <= 12'h357 |=> rd_data_q[15:8] == 8'h00;
  endproperty
  property p_fuse_pulse;
    ce && fuse_rd_q |=> !fuse_rd_q [*2];
  endproperty
  property p_fuse_next;
    ce && fuse_rd_q && fuse_addr_q < NUM_TRIM - 1
      |-> ##3 (fuse_rd_q && fuse_addr_q == $past(fuse_addr_q, 3) + 4'h1);
  endproperty
  property p_busy_end;
    ce && fuse_rd_q && fuse_addr_q == NUM_TRIM - 1 |-> load_busy_q ##[1:3] !load_busy_q;
  endproperty
  property p_cal_off;
    !fg_q && !$past(fg_q) && $past(ce)
      |-> off_a_in_b_qtr_q == '0 && off_b_in_a_q == '0 && off_b_in_b_q == '0;
  endproperty
  property p_qtr_off;
    $past(ce) && !$past(sample_a_in_b_quarter) |-> off_a_in_b_qtr_q == '0;
  endproperty
  property p_reload;
    ce && wr_en && addr == atb_pkg::ADDR_CTRL && wr_data[0] |=> ##[0:2] load_busy_q;
  endproperty

  a_readback: assert property (p_readback) else $error("readback differs");
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  a_gain_hi: assert property (p_gain_hi) else $error("gain upper byte set");
  a_fuse_pulse: assert property (p_fuse_pulse) else $error("fuse strobe spacing");
  a_fuse_next: assert property (p_fuse_next) else $error("fuse index order");
  a_busy_end: assert property (p_busy_end) else $error("load busy stuck");
  a_cal_off: assert property (p_cal_off) else $error("offset without cal");
  a_qtr_off: assert property (p_qtr_off) else $error("quarter offset leaked");
  a_reload: assert property (p_reload) else $error("reload not started");
endmodule

bind atb_trim_bank atb_trim_bank_chk #(
  .ADDR_W(ADDR_W), .DATA_W(DATA_W), .NUM_TRIM(NUM_TRIM)
) u_chk (
  .clk(clk), .resetn(resetn), .ce(ce), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data_q(rd_data_q), .sample_a_in_b_quarter(sample_a_in_b_quarter),
  .fuse_rd_q(fuse_rd_q), .fuse_addr_q(fuse_addr_q), .fuse_data(fuse_data),
  .load_busy_q(load_busy_q), .off_a_in_b_qtr_q(off_a_in_b_qtr_q),
  .off_b_in_a_q(off_b_in_a_q),
  .off_b_in_b_q(off_b_in_b_q), .gain_a0_q(gain_a0_q), .gain_a1_q(gain_a1_q),
  .gain_b0_q(gain_b0_q), .gain_b1_q(gain_b1_q)
);
`default_nettype wire

// >>> bench/test_atb_trim_bank.sv
// Self-checking bench of the trim register bank
`timescale 1ns/10ps
`default_nettype none
module test_atb_trim_bank;
  logic        clk, resetn, ce, wr_en, rd_en, smp, fuse_rd_q, load_busy_q, fg, sgl;
  logic [11:0] addr, oa, ob, oc;
  logic [15:0] wr_data, rd_data_q, fuse_data, salt;
  logic [3:0]  fuse_addr_q;
  logic [4:0]  g0, g1, g2, g3;
  logic [15:0] mem [11];
  int          fails, n_tests;

  atb_trim_bank dut (
    .clk(clk), .resetn(resetn), .ce(ce), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data_q(rd_data_q), .sample_a_in_b_quarter(smp), .fuse_rd_q(fuse_rd_q),
    .fuse_addr_q(fuse_addr_q), .fuse_data(fuse_data), .load_busy_q(load_busy_q),
    .off_a_in_b_qtr_q(oa), .off_b_in_a_q(ob), .off_b_in_b_q(oc), .gain_a0_q(g0),
    .gain_a1_q(g1), .gain_b0_q(g2), .gain_b1_q(g3));

  // ==========================================================
  // Clock and fuse ROM
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [15:0] fw(input logic [3:0] i);
    return (salt ^ {4{i}}) & (i < 4'h3 ? 16'h0fff : 16'h001f);
  endfunction
  always @(posedge clk) fuse_data <= fuse_rd_q ? fw(fuse_addr_q) : ~fuse_data;

  // ==========================================================
  // Expectations
  function automatic logic [15:0] wexp(input int i, input logic [15:0] d);
    return i < 3 ? d : {8'h00, d[7:0]};
  endfunction
  function automatic logic [55:0] cexp();
    int k;
    k = sgl ? 7 : 3;
    return {(fg && smp) ? mem[0][11:0] : 12'h000, fg ? mem[1][11:0] : 12'h000,
            fg ? mem[2][11:0] : 12'h000, mem[k][4:0], mem[k+1][4:0], mem[k+2][4:0],
            mem[k+3][4:0]};
  endfunction

  // ==========================================================
  // Bus and compare tasks
  task automatic bus(input logic w, r, input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_en <= w;
    rd_en <= r;
    addr <= a;
    wr_data <= d;
  endtask
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge clk);
      wr_en <= 1'b0;
      rd_en <= 1'b0;
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    bus(1'b0, 1'b1, a, 16'h0000);
    cyc(1);
    #1;
    n_tests++;
    if (rd_data_q !== e) begin
      fails++;
      $display("unexpected read %h: expected %h, seen %h", a, e, rd_data_q);
    end
  endtask
  task automatic chk_core();
    cyc(3);
    #1;
    n_tests++;
    if ({oa, ob, oc, g0, g1, g2, g3} !== cexp()) begin
      fails++;
      $display("unexpected core outputs: expected %h, seen %h", cexp(),
               {oa, ob, oc, g0, g1, g2, g3});
    end
  endtask
  task automatic wt(input int i, input logic [15:0] d);
    bus(1'b1, 1'b0, atb_pkg::REG_ADDR[i], d);
    mem[i] = wexp(i, d);
  endtask
  task automatic ctl(input logic [15:0] d);
    bus(1'b1, 1'b0, atb_pkg::ADDR_CTRL, d);
    fg = d[2];
    sgl = d[3];
    if (d[0]) for (int i = 0; i < 11; i++) mem[i] = fw(4'(i));
  endtask
  task automatic wait_load();
    int n;
    n = 0;
    cyc(2);
    while (load_busy_q !== 1'b0 && n < 100) begin
      cyc(1);
      n++;
    end
    if (n >= 100) begin
      fails++;
      $display("unexpected load_busy_q: expected 0, seen %b", load_busy_q);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================
  // Watchdog and main sequence
  initial begin
    #200000;
    fails++;
    $display("unexpected run time: expected end, seen hang");
    conclude();
  end
  initial begin
    {resetn, wr_en, rd_en, smp, fg, sgl} = '0;
    ce = 1'b1;
    addr = '0;
    wr_data = '0;
    fails = 0;
    n_tests = 0;
    void'($urandom(32'hda4d));
    salt = 16'($urandom);
    for (int i = 0; i < 11; i++) mem[i] = fw(4'(i));
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    wait_load();
    rd(atb_pkg::ADDR_CTRL, 16'h0000);
    for (int i = 0; i < 11; i++) rd(atb_pkg::REG_ADDR[i], mem[i]);
    chk_core();
    rd(12'h34b, 16'h0000);
    rd(12'h358, 16'h0000);
    for (int t = 0; t < 64; t++) begin
      int i;
      logic [15:0] d;
      i = t < 2 ? t * 3 : $urandom_range(10);
      d = t < 2 ? 16'hffff : 16'($urandom);
      if (t % 4 == 0) ctl({12'h000, 2'(t / 4), 2'b00});
      if (t % 4 == 0) rd(atb_pkg::ADDR_CTRL, {12'h000, sgl, fg, 2'b00});
      @(posedge clk);
      smp <= 1'($urandom);
      wt(i, d);
      rd(atb_pkg::REG_ADDR[i], mem[i]);
      chk_core();
    end
    ctl(16'h0005);
    cyc(2);
    bus(1'b1, 1'b0, atb_pkg::REG_ADDR[0], 16'h0abc);
    wait_load();
    for (int i = 0; i < 11; i++) rd(atb_pkg::REG_ADDR[i], mem[i]);
    chk_core();
    @(posedge clk);
    ce <= 1'b0;
    bus(1'b1, 1'b0, atb_pkg::REG_ADDR[3], 16'h0011);
    cyc(1);
    ce <= 1'b1;
    rd(atb_pkg::REG_ADDR[3], mem[3]);
    conclude();
  end
endmodule
`default_nettype wire
